// ### rtl/ofp_top.sv
// Output fault protection: UV/OV sticky flags, driver gating, OT shutdown,
// AXI4-Lite register slave.
// Assumes comparator pins are asynchronous and active high; threshold
// registers drive the external DACs.
`include "ofp_defs.svh"
`timescale 1ns/1ps
module ofp_top
	import ofp_pkg::*;
#(
	parameter int OT_FILT = `OFP_OT_FILT_CYC
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        uv_cmp_in,
	input  wire logic        ov_cmp_in,
	input  wire logic        ot_cmp_in,
	input  wire logic        pwm_high_in,
	input  wire logic        pwm_low_in,
	output logic [7:0]       uv_threshold_out,
	output logic [7:0]       ov_threshold_out,
	output logic             uv_dac_en_out,
	output logic             ov_dac_en_out,
	output logic             high_side_gate_out,
	output logic             low_side_gate_out
);
	// ****************************************************
	// Declarations
	// ****************************************************
	ofp_byte_t   analog_block_enable_reg_q;  // DAC enables
	ofp_byte_t   uv_threshold_reg_q;         // UV DAC code
	ofp_byte_t   ov_threshold_reg_q;         // OV DAC code
	ofp_byte_t   protection_enable_reg_q;    // Shutdown enables
	ofp_byte_t   irq_control_reg_q;          // Interrupt control
	ofp_byte_t   analog_test_ctrl_reg_q;     // Driver disables
	logic        uv_fault_flag_q;            // Sticky UV
	logic        ov_fault_flag_q;            // Sticky OV
	logic        ot_shutdown_q;              // OT latched
	logic [7:0]  ot_cnt_q;                   // OT filter count
	logic [2:0]  cmp_sync;                   // Synchronised pins
	logic [1:0]  pwm_q;                      // Registered PWM
	logic        aw_held_q;                  // Address captured
	logic        w_held_q;                   // Data captured
	logic [7:0]  awaddr_q;                   // Write address
	logic [31:0] wdata_q;                    // Write data
	logic [3:0]  wstrb_q;                    // Write strobes
	ofp_rd_e     rd_state_q;                 // Read channel state
	logic        wr_fire;                    // Write commit
	logic        fault_gate;                 // Drivers forced low
	logic        uv_cond;                    // Qualified UV
	logic        ov_cond;                    // Qualified OV
	logic        uv_clr;                     // Firmware UV clear
	logic        ov_clr;                     // Firmware OV clear

	// ****************************************************
	// Elaboration check
	// ****************************************************
	initial
	begin
		if (OT_FILT < 1 || OT_FILT > 255)
			$error("ofp_top: OT_FILT out of range");
	end

	// Write decode used by several processes
	function automatic logic wr_hit(input logic [7:0] a,
		input logic [7:0] off);
		wr_hit = (a == off);
	endfunction

	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	ofp_sync #(.WIDTH(3)) u_sync
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({ot_cmp_in, ov_cmp_in, uv_cmp_in}),
		.sync_out (cmp_sync)
	);

	// ****************************************************
	// AXI write channel
	// ****************************************************
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	// Capture address and data in either order, answer after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `OFP_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				// Response once both halves are in
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0
					&& !wr_hit(awaddr_q, `OFP_ADDR_STAT))
					? `OFP_RESP_OKAY : `OFP_RESP_SLVERR;
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************************
	// Control registers
	// ****************************************************
	// Byte lane 0 writes control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			analog_block_enable_reg_q <= `OFP_RST_BYTE;
			uv_threshold_reg_q        <= `OFP_RST_BYTE;
			ov_threshold_reg_q        <= `OFP_RST_BYTE;
			protection_enable_reg_q   <= `OFP_RST_BYTE;
			irq_control_reg_q         <= `OFP_RST_BYTE;
			analog_test_ctrl_reg_q    <= `OFP_RST_TEST;
		end
		else if (wr_fire && wstrb_q[0])
		begin
			if (wr_hit(awaddr_q, `OFP_ADDR_ABE))
				analog_block_enable_reg_q <= wdata_q[7:0];
			if (wr_hit(awaddr_q, `OFP_ADDR_UVTH))
				uv_threshold_reg_q <= wdata_q[7:0];
			if (wr_hit(awaddr_q, `OFP_ADDR_OVTH))
				ov_threshold_reg_q <= wdata_q[7:0];
			if (wr_hit(awaddr_q, `OFP_ADDR_PROT))
				protection_enable_reg_q <= wdata_q[7:0];
			if (wr_hit(awaddr_q, `OFP_ADDR_IRQC))
				irq_control_reg_q <= wdata_q[7:0];
			if (wr_hit(awaddr_q, `OFP_ADDR_TEST))
				analog_test_ctrl_reg_q <= wdata_q[7:0];
		end
	end

	// ****************************************************
	// Fault flags
	// ****************************************************
	// Comparators only count while their DAC runs
	assign uv_cond = cmp_sync[0]
		&& analog_block_enable_reg_q[`OFP_BIT_UVDAC];
	assign ov_cond = cmp_sync[1]
		&& analog_block_enable_reg_q[`OFP_BIT_OVDAC];
	// Write one to clear, lane 0 only
	assign uv_clr = wr_fire && wstrb_q[0] && wr_hit(awaddr_q, `OFP_ADDR_FLAG)
		&& wdata_q[`OFP_BIT_UVF];
	assign ov_clr = wr_fire && wstrb_q[0] && wr_hit(awaddr_q, `OFP_ADDR_FLAG)
		&& wdata_q[`OFP_BIT_OVF];

	// Sticky flags, set beats clear, no interrupt enable involved
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			uv_fault_flag_q <= 1'b0;
			ov_fault_flag_q <= 1'b0;
		end
		else
		begin
			uv_fault_flag_q <= uv_cond || (uv_fault_flag_q && !uv_clr);
			ov_fault_flag_q <= ov_cond || (ov_fault_flag_q && !ov_clr);
		end
	end

	// ****************************************************
	// Overtemperature shutdown
	// ****************************************************
	// Latch after a filtered trip; only reset clears it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ot_cnt_q      <= 8'h00;
			ot_shutdown_q <= 1'b0;
		end
		else if (!cmp_sync[2])
			ot_cnt_q <= 8'h00;
		else if (ot_cnt_q >= 8'(OT_FILT - 1))
			ot_shutdown_q <= 1'b1;
		else
			ot_cnt_q <= ot_cnt_q + 8'h01;
	end

	// ****************************************************
	// Gate drive outputs
	// ****************************************************
	assign fault_gate = ot_shutdown_q
		|| (uv_fault_flag_q
			&& protection_enable_reg_q[`OFP_BIT_UVSD])
		|| (ov_fault_flag_q
			&& protection_enable_reg_q[`OFP_BIT_OVSD]);

	// Register PWM and apply gating and individual disables
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_q              <= 2'b00;
			high_side_gate_out <= 1'b0;
			low_side_gate_out  <= 1'b0;
		end
		else
		begin
			pwm_q <= {pwm_low_in, pwm_high_in};
			high_side_gate_out <= pwm_q[0] && !fault_gate
				&& !analog_test_ctrl_reg_q[`OFP_BIT_HIGH_DRIVER_DISABLE];
			low_side_gate_out  <= pwm_q[1] && !fault_gate
				&& !analog_test_ctrl_reg_q[`OFP_BIT_LOW_DRIVER_DISABLE];
		end
	end

	// DAC outputs follow their registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			uv_threshold_out <= `OFP_RST_BYTE;
			ov_threshold_out <= `OFP_RST_BYTE;
			uv_dac_en_out    <= 1'b0;
			ov_dac_en_out    <= 1'b0;
		end
		else
		begin
			uv_threshold_out <= uv_threshold_reg_q;
			ov_threshold_out <= ov_threshold_reg_q;
			uv_dac_en_out    <= analog_block_enable_reg_q[`OFP_BIT_UVDAC];
			ov_dac_en_out    <= analog_block_enable_reg_q[`OFP_BIT_OVDAC];
		end
	end

	// ****************************************************
	// AXI read channel
	// ****************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_q    <= OFP_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `OFP_RESP_OKAY;
		end
		else
		begin
			case (rd_state_q)
				OFP_RD_IDLE:
				begin
					s_axi_arready <= s_axi_arvalid && !s_axi_arready;
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rresp   <= `OFP_RESP_OKAY;
						rd_state_q    <= OFP_RD_RESP;
						case (s_axi_araddr)
							`OFP_ADDR_ABE:  s_axi_rdata <= {24'h00_0000, analog_block_enable_reg_q};
							`OFP_ADDR_UVTH: s_axi_rdata <= {24'h00_0000, uv_threshold_reg_q};
							`OFP_ADDR_OVTH: s_axi_rdata <= {24'h00_0000, ov_threshold_reg_q};
							`OFP_ADDR_FLAG: s_axi_rdata <= {30'h0000_0000, ov_fault_flag_q, uv_fault_flag_q};
							`OFP_ADDR_PROT: s_axi_rdata <= {24'h00_0000, protection_enable_reg_q};
							`OFP_ADDR_IRQC: s_axi_rdata <= {24'h00_0000, irq_control_reg_q};
							`OFP_ADDR_TEST: s_axi_rdata <= {24'h00_0000, analog_test_ctrl_reg_q};
							`OFP_ADDR_STAT: s_axi_rdata <= {30'h0000_0000, fault_gate, ot_shutdown_q};
							default:
							begin
								s_axi_rdata <= 32'h0000_0000;
								s_axi_rresp <= `OFP_RESP_SLVERR;
							end
						endcase
					end
				end
				OFP_RD_RESP:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rd_state_q   <= OFP_RD_IDLE;
					end
				end
				default:
					rd_state_q <= OFP_RD_IDLE;
			endcase
		end
	end

	// ****************************************************
	// Assertions
	// ****************************************************
	chk_uv_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		uv_cond |=> uv_fault_flag_q)
		else $error("UV flag not set");
	chk_uv_dac_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(!uv_fault_flag_q && !analog_block_enable_reg_q[`OFP_BIT_UVDAC]) |=> !uv_fault_flag_q)
		else $error("UV set with DAC off");
	chk_ov_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ov_cond |=> ov_fault_flag_q)
		else $error("OV flag not set");
	chk_ov_dac_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ov_fault_flag_q && !analog_block_enable_reg_q[`OFP_BIT_OVDAC]) |=> !ov_fault_flag_q)
		else $error("OV set with DAC off");
	chk_uv_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(uv_fault_flag_q && !uv_clr) |=> uv_fault_flag_q)
		else $error("UV flag dropped");
	chk_uv_drv_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(uv_fault_flag_q && protection_enable_reg_q[`OFP_BIT_UVSD]) |=> !high_side_gate_out && !low_side_gate_out)
		else $error("Drivers on during UV");
	chk_ov_drv_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(ov_fault_flag_q && protection_enable_reg_q[`OFP_BIT_OVSD]) |=> !high_side_gate_out && !low_side_gate_out)
		else $error("Drivers on during OV");
	chk_ot_latch: assert property (@(posedge aclk) disable iff (!aresetn)
		ot_shutdown_q |=> ot_shutdown_q && !high_side_gate_out && !low_side_gate_out)
		else $error("OT shutdown released");
	chk_hi_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		analog_test_ctrl_reg_q[`OFP_BIT_HIGH_DRIVER_DISABLE] |=> !high_side_gate_out)
		else $error("High driver on while disabled");
	chk_irq_indep: assert property (@(posedge aclk) disable iff (!aresetn)
		(ov_cond && !irq_control_reg_q[`OFP_BIT_GIE]) |=> ov_fault_flag_q)
		else $error("Flag blocked by GLOBAL_IRQ_ENABLE");
	chk_ov_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(ov_fault_flag_q && !ov_clr) |=> ov_fault_flag_q)
		else $error("OV flag dropped");
	chk_lo_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		analog_test_ctrl_reg_q[`OFP_BIT_LOW_DRIVER_DISABLE] |=> !low_side_gate_out)
		else $error("Low driver on while disabled");
endmodule

// ### common/ofp_defs.svh
// Constants for the output fault protection block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32-bit AXI4-Lite slave and a 10 MHz core clock.
//
// Overview of operation
// - UV compare only while UV DAC enabled
// - Output below UV threshold sets UV flag
// - UV shutdown enable holds both drivers low
// - OV compare only while OV DAC enabled
// - Output above OV threshold sets OV flag
// - OV shutdown enable holds both drivers low
// - Flags set regardless of interrupt enables
// - Overtemperature shuts converter down in hardware
// - Individually disabled driver output goes low
`ifndef OFP_DEFS_SVH
`define OFP_DEFS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define OFP_ADDR_ABE     8'h00
`define OFP_ADDR_UVTH    8'h04
`define OFP_ADDR_OVTH    8'h08
`define OFP_ADDR_FLAG    8'h0C
`define OFP_ADDR_PROT    8'h10
`define OFP_ADDR_IRQC    8'h14
`define OFP_ADDR_TEST    8'h18
`define OFP_ADDR_STAT    8'h1C

// ****************************************************
// Field positions
// ****************************************************
`define OFP_BIT_UVDAC    0
`define OFP_BIT_OVDAC    1
`define OFP_BIT_UVF      0
`define OFP_BIT_OVF      1
`define OFP_BIT_UVSD     0
`define OFP_BIT_OVSD     1
`define OFP_BIT_GIE      7
`define OFP_BIT_HIGH_DRIVER_DISABLE    0
`define OFP_BIT_LOW_DRIVER_DISABLE    1
`define OFP_BIT_OTSD     0
`define OFP_BIT_GATE     1

// ****************************************************
// Reset values and bus answers
// ****************************************************
`define OFP_RST_BYTE     8'h00
`define OFP_RST_TEST     8'h03
`define OFP_RESP_OKAY    2'b00
`define OFP_RESP_SLVERR  2'b10

// ****************************************************
// Overtemperature trip and filter timing
// ****************************************************
`define OFP_OT_TRIP_C    160
`define OFP_OT_FILT_NS   400
`define OFP_CLK_NS       100
`define OFP_OT_FILT_CYC  ((`OFP_OT_FILT_NS + `OFP_CLK_NS - 1) / `OFP_CLK_NS)

`endif

// ### common/ofp_pkg.sv
// Types for the output fault protection block.
// Assumes ofp_defs.svh provides the numeric constants.
package ofp_pkg;
	typedef logic [7:0] ofp_byte_t;
	typedef enum logic [1:0] {
		OFP_RD_IDLE,
		OFP_RD_RESP
	} ofp_rd_e;
endpackage

// ### rtl/ofp_sync.sv
// Two-flop synchroniser bank for asynchronous comparator pins.
// Assumes inputs are asynchronous levels; the first stage feeds only the
// second.
`timescale 1ns/1ps
module ofp_sync
	import ofp_pkg::*;
#(
	parameter int WIDTH = 3
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;     // First stage

	// ****************************************************
	// Width check
	// ****************************************************
	initial
	begin
		if (WIDTH < 1)
			$error("ofp_sync: WIDTH must be positive");
	end

	// Two flip-flops per bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ### testbench/tb_top.sv
// Self-checking testbench for the output fault protection block.
// Assumes ofp_top with its AXI4-Lite slave and a 100 ns core clock.
`timescale 1ns/1ps
module tb_top;
	// ****************************************************
	// Signals
	// ****************************************************
	localparam int OT_F = 4;      // Overtemperature filter length
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic [31:0] wdata;
	logic [3:0]  wstrb;           // Write strobes
	logic        wvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        rready;
	logic [1:0]  cmp_v;           // UV and OV comparator levels
	logic        ot_in;
	logic        pwm_h;
	logic        pwm_l;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd, v;
	logic [7:0]  uv_th, ov_th, th;
	logic        uv_den, ov_den, hg, lg;
	int          num_errors;
	int          checked;
	int          seed;

	ofp_top #(.OT_FILT(OT_F)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .uv_cmp_in(cmp_v[0]),
		.ov_cmp_in(cmp_v[1]), .ot_cmp_in(ot_in),
		.pwm_high_in(pwm_h), .pwm_low_in(pwm_l),
		.uv_threshold_out(uv_th), .ov_threshold_out(ov_th),
		.uv_dac_en_out(uv_den), .ov_dac_en_out(ov_den),
		.high_side_gate_out(hg), .low_side_gate_out(lg)
	);

	// Free-running core clock
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	// ****************************************************
	// Helpers
	// ****************************************************
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim;
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Expected gates from {pwm_l, pwm_h, low_dis, high_dis}
	function automatic logic [1:0] exp_gate(input logic [3:0] s);
		return {s[2] & ~s[0], s[3] & ~s[1]};
	endfunction

	// AXI4-Lite write; response left in resp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_ok;
		logic w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 40)
		begin
			@(posedge aclk);
			n++;
			if (!aw_ok && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1 && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n >= 40)
			chk(32'(n), 32'h0000_0000, "write hang");
		@(posedge aclk);
	endtask

	// AXI4-Lite read; data in rd, response in resp
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (arready !== 1'b1 && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 40);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 40)
			chk(32'(n), 32'h0000_0000, "read hang");
		@(posedge aclk);
	endtask

	// One UV (k=0) or OV (k=1) pass, shutdown enable sd
	task automatic fault_case(input int k, input logic sd);
		logic [31:0] m;
		logic g;
		m = 32'h0000_0001 << k;
		g = ~sd;
		pwm_h <= 1'b1;
		pwm_l <= 1'b1;
		wr(8'h14, {24'h0, sd, 7'h0});
		wr(8'h10, sd ? m : 32'h0000_0000);
		wr(8'h18, 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		cmp_v[k] <= 1'b1;
		repeat (8) @(posedge aclk);
		rdr(8'h0C);
		chk(rd, 32'h0000_0000, "flag with dac off");
		chk(32'({hg, lg}), 32'h0000_0003, "gates run");
		wr(8'h00, m);
		repeat (8) @(posedge aclk);
		rdr(8'h0C);
		chk(rd, m, "flag set");
		chk(32'({ov_den, uv_den}), m, "dac enable");
		chk(32'({hg, lg}), 32'({g, g}), "gate fault");
		rdr(8'h1C);
		chk(32'(rd[1]), 32'(sd), "gating status");
		cmp_v[k] <= 1'b0;
		wr(8'h0C, 32'h0000_0000);
		repeat (8) @(posedge aclk);
		rdr(8'h0C);
		chk(rd, m, "flag sticky");
		chk(32'({hg, lg}), 32'({g, g}), "gates held");
		wr(8'h0C, m);
		repeat (4) @(posedge aclk);
		rdr(8'h0C);
		chk(rd, 32'h0000_0000, "flag cleared");
		chk(32'({hg, lg}), 32'h0000_0003, "released");
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial
	begin
		seed = 32'h21af3902;
		num_errors = 0;
		checked = 0;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, cmp_v, ot_in, pwm_h, pwm_l} = '0;
		wstrb = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset state: drivers disabled, no flags
		rdr(8'h18);
		chk(rd, 32'h0000_0003, "driver disable reset");
		rdr(8'h0C);
		chk(rd, 32'h0000_0000, "flag reset");
		chk(32'({hg, lg}), 32'h0000_0000, "gates at reset");
		// Random thresholds with read-back
		for (int i = 0; i < 6; i++)
		begin
			v = $random(seed);
			wr(8'h04 + 8'(4 * (i % 2)), {24'h0, v[7:0]});
			rdr(8'h04 + 8'(4 * (i % 2)));
			chk(rd, {24'h0, v[7:0]}, "threshold");
			th = (i % 2) ? ov_th : uv_th;
			chk(32'(th), 32'(v[7:0]), "dac code");
		end
		// Unmapped read and read-only write
		rdr(8'h20);
		chk(32'(resp), 32'h0000_0002, "unmapped read resp");
		chk(rd, 32'h0000_0000, "unmapped read data");
		wr(8'h1C, 32'h0000_0003);
		chk(32'(resp), 32'h0000_0002, "status write resp");
		// Lane 0 strobe off leaves the register alone
		wr(8'h04, 32'h0000_005a);
		wstrb <= 4'he;
		wr(8'h04, 32'h0000_00a5);
		wstrb <= 4'hf;
		rdr(8'h04);
		chk(rd, 32'h0000_005a, "strobe lane 0");
		// UV and OV, with and without shutdown
		for (int k = 0; k < 2; k++)
			for (int s = 0; s < 2; s++)
				fault_case(k, s[0]);
		// Driver disable against pwm, corners then random
		for (int i = 0; i < 12; i++)
		begin
			v = (i < 4) ? (32'h0000_000C | i) : $random(seed);
			pwm_h <= v[2];
			pwm_l <= v[3];
			wr(8'h18, {30'h0, v[1:0]});
			repeat (4) @(posedge aclk);
			chk(32'({hg, lg}), 32'(exp_gate(v[3:0])), "gate");
		end
		// Overtemperature: short pulse ignored, long one latches
		wr(8'h18, 32'h0000_0000);
		pwm_h <= 1'b1;
		pwm_l <= 1'b1;
		ot_in <= 1'b1;
		repeat (OT_F - 1) @(posedge aclk);
		ot_in <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'({hg, lg}), 32'h0000_0003, "short hot pulse");
		ot_in <= 1'b1;
		repeat (OT_F + 2) @(posedge aclk);
		ot_in <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'({hg, lg}), 32'h0000_0000, "hot shutdown");
		rdr(8'h1C);
		chk(32'(rd[0]), 32'h0000_0001, "hot latched");
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(8'h1C);
		chk(32'(rd[0]), 32'h0000_0000, "hot after reset");
		end_sim;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		end_sim;
	end
endmodule
